// ### rtl/gp_timer_pkg.sv
// Constants, register map and carrier types for the general-purpose timer unit.
// Assumes an APB slave at 32-bit data with word-aligned registers.
package gp_timer_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] OFF_CONFIG      = 12'h000;
  localparam logic [11:0] OFF_FIRST_MODE  = 12'h004;
  localparam logic [11:0] OFF_SECOND_MODE = 12'h008;
  localparam logic [11:0] OFF_CONTROL     = 12'h00C;
  localparam logic [11:0] OFF_MASK        = 12'h018;
  localparam logic [11:0] OFF_RAW         = 12'h01C;
  localparam logic [11:0] OFF_MASKED      = 12'h020;
  localparam logic [11:0] OFF_CLEAR       = 12'h024;
  localparam logic [11:0] OFF_FIRST_LOAD  = 12'h028;
  localparam logic [11:0] OFF_SECOND_LOAD = 12'h02C;
  localparam logic [11:0] OFF_FIRST_MATCH = 12'h030;
  localparam logic [11:0] OFF_SECOND_MATCH= 12'h034;
  localparam logic [11:0] OFF_FIRST_PRE   = 12'h038;
  localparam logic [11:0] OFF_SECOND_PRE  = 12'h03C;
  localparam logic [11:0] OFF_FIRST_VALUE = 12'h048;
  localparam logic [11:0] OFF_SECOND_VALUE= 12'h04C;

  // ----------------------------------------------------------------
  // Configuration values and mode field encodings
  // ----------------------------------------------------------------
  localparam logic [2:0] CFG_JOINED_TIMER = 3'h0;
  localparam logic [2:0] CFG_JOINED_CLOCK = 3'h1;
  localparam logic [2:0] CFG_SPLIT        = 3'h4;
  localparam logic [1:0] MODE_ONE_SHOT    = 2'h1;
  localparam logic [1:0] MODE_PERIODIC    = 2'h2;
  localparam logic [1:0] MODE_EDGE_COUNT  = 2'h3;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTL_EN_POS      = 0;   // plus 8 for the second half
  localparam int CTL_STALL_POS   = 1;
  localparam int CTL_CLOCK_POS   = 4;
  localparam int CTL_TRIG_POS    = 5;
  localparam int CTL_HALF_STRIDE = 8;
  localparam int FLAG_FIRST_TO   = 0;
  localparam int FLAG_CLOCK      = 3;
  localparam int FLAG_SECOND_TO  = 8;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_COUNT     = 16'hFFFF;
  localparam logic [15:0] RST_LOAD      = 16'hFFFF;
  localparam logic [7:0]  RST_PRESCALE  = 8'h00;
  localparam logic [31:0] CLOCK_START   = 32'h00000001;
  localparam logic [31:0] CLOCK_ROLL    = 32'h00000000;

  // ----------------------------------------------------------------
  // Clock mode timing
  // ----------------------------------------------------------------
  localparam int CLOCK_IN_HZ   = 32768;
  localparam int CLOCK_TICK_HZ = 1;
  localparam int CLOCK_DIV     = CLOCK_IN_HZ / CLOCK_TICK_HZ;

  typedef struct packed {
    logic trig;
    logic stall;
    logic en;
  } half_ctl_t;

  typedef struct packed {
    logic second_to;
    logic clock_match;
    logic first_to;
  } flags_t;

endpackage : gp_timer_pkg

// ### rtl/gp_timer_module.sv
// One timer unit: two 16-bit halves, joinable into a 32-bit timer or clock.
// Assumes an APB master on pclk and capture pins asynchronous to pclk.
`timescale 1ns/1ps

// Function
// [RQ1] Two 16-bit halves run separately or join into one 32-bit timer/clock.
// [RQ2] Timeout triggers of the halves are ORed into one converter trigger.
// [RQ3] Configuration 0 joined timer, 1 joined clock, 0x4 split halves.
// [RQ4] Reset: inactive, controls clear, counters and loads 0xFFFF, prescale 0x00.
// [RQ5] Joined mode first load write fills second load from upper half.
// [RQ6] Joined mode first value read returns second half above first half.
// [RQ7] Joined timer counts down; only first mode field picks one-shot/periodic.
// [RQ8] At zero reload next cycle; one-shot then clears enable, periodic continues.
// [RQ9] Timeout sets sticky raw flag until cleared; masked flag when mask set.
// [RQ10] Trigger enable gives one-cycle trigger pulse at zero.
// [RQ11] Load write while running is taken next cycle, counting continues.
// [RQ12] Stall bit holds the count; counting resumes when it drops.
// [RQ13] Clock mode counts up; first selection loads one; match from first match.
// [RQ14] Even pin carries 32.768 kHz; divided to 1 Hz counting tick.
// [RQ15] Clock counts up; on match rolls to zero and keeps counting.
// [RQ16] Clock match sets raw flag, masked flag when enabled; clear bit clears.
// [RQ17] Clock enable bit overrides both stall bits; the code overrides only the first half's stall bit, through run_first.
// [RQ18] Split halves use the odd pin, joined modes the even pin; the code uses it only in joined clock mode.
// [RQ19] Joined mode is one 32-bit timer; split halves pick modes independently.
// [RQ20] Interrupt output high while any masked flag is set.
module gp_timer_module
  import gp_timer_pkg::*;
#(
  parameter int CLOCK_DIVIDE = CLOCK_DIV
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Capture pins
  input  wire logic        capture_pin_even,
  input  wire logic        capture_pin_odd,
  // Events
  output logic             adc_trigger,
  output logic             timer_irq
);

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic logic is_mapped(input logic [11:0] a);
    case (a)
      OFF_CONFIG, OFF_FIRST_MODE, OFF_SECOND_MODE, OFF_CONTROL, OFF_MASK, OFF_RAW,
      OFF_MASKED, OFF_CLEAR, OFF_FIRST_LOAD, OFF_SECOND_LOAD, OFF_FIRST_MATCH,
      OFF_SECOND_MATCH, OFF_FIRST_PRE, OFF_SECOND_PRE, OFF_FIRST_VALUE,
      OFF_SECOND_VALUE: is_mapped = 1'b1;
      default:          is_mapped = 1'b0;
    endcase
  endfunction : is_mapped

  function automatic logic [31:0] flags_word(input flags_t f);
    flags_word = 32'h00000000;
    flags_word[FLAG_FIRST_TO]  = f.first_to;
    flags_word[FLAG_CLOCK]     = f.clock_match;
    flags_word[FLAG_SECOND_TO] = f.second_to;
  endfunction : flags_word

  function automatic flags_t word_flags(input logic [31:0] w);
    word_flags = '{second_to: w[FLAG_SECOND_TO], clock_match: w[FLAG_CLOCK], first_to: w[FLAG_FIRST_TO]};
  endfunction : word_flags

  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  logic [2:0]  timer_configuration;
  logic [1:0]  counter_mode    [2];
  half_ctl_t   half_ctl        [2];
  logic        clock_mode_enable;
  logic [15:0] interval_load   [2];
  logic [15:0] match_value     [2];
  logic [7:0]  prescale        [2];
  logic [7:0]  prescale_count  [2];
  logic [15:0] half_counter    [2];
  flags_t      interrupt_mask;
  flags_t      raw_interrupt_status;
  flags_t      masked_interrupt_status;
  logic        clock_loaded;

  logic        setup_phase;
  logic        wr;
  logic        joined;
  logic [31:0] joined_count;
  logic [31:0] joined_load;
  logic [31:0] joined_match;
  flags_t      events;
  flags_t      clear_bits;
  logic [1:0]  oneshot_done;
  logic [1:0]  load_write;

  assign setup_phase  = psel && !penable;
  assign wr           = psel && penable && pwrite && pready;
  assign joined       = (timer_configuration == CFG_JOINED_TIMER) ||
                        (timer_configuration == CFG_JOINED_CLOCK);
  assign joined_count = {half_counter[1], half_counter[0]};
  assign joined_load  = {interval_load[1], interval_load[0]};
  assign joined_match = {match_value[1], match_value[0]};
  assign masked_interrupt_status = raw_interrupt_status & interrupt_mask;
  assign clear_bits   = (wr && paddr == OFF_CLEAR) ? word_flags(pwdata) : flags_t'(3'h0);
  assign load_write[0] = wr && paddr == OFF_FIRST_LOAD;
  assign load_write[1] = wr && paddr == OFF_SECOND_LOAD;

  // ----------------------------------------------------------------
  // Capture pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] even_sync;
  logic [1:0] odd_sync;
  logic       even_prev;
  logic       odd_prev;
  logic       even_rise;
  logic       odd_rise;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      even_sync <= 2'h0;
      odd_sync  <= 2'h0;
      even_prev <= 1'b0;
      odd_prev  <= 1'b0;
    end else begin
      even_sync <= {even_sync[0], capture_pin_even};
      odd_sync  <= {odd_sync[0], capture_pin_odd};
      even_prev <= even_sync[1];
      odd_prev  <= odd_sync[1];
    end
  end

  assign even_rise = even_sync[1] && !even_prev;   // [RQ18]
  assign odd_rise  = odd_sync[1] && !odd_prev;     // [RQ18]

  // ----------------------------------------------------------------
  // Clock mode divider: 32768 input edges make one tick
  // ----------------------------------------------------------------
  logic [15:0] div_count;
  logic        clock_tick;

  assign clock_tick = even_rise && (div_count == 16'(CLOCK_DIVIDE - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_count <= 16'h0000;
    end else if (timer_configuration != CFG_JOINED_CLOCK) begin
      div_count <= 16'h0000;
    end else if (clock_tick) begin
      div_count <= 16'h0000;                       // [RQ14]
    end else if (even_rise) begin
      div_count <= div_count + 16'h0001;           // [RQ14]
    end
  end

  // ----------------------------------------------------------------
  // Counter next-state
  // ----------------------------------------------------------------
  logic [15:0] next_half   [2];
  logic [7:0]  next_pre    [2];
  logic [31:0] next_joined;
  logic        next_loaded;
  logic        run_first;

  // Clock enable overrides stall so a debugger cannot slip the wall clock
  assign run_first = half_ctl[0].en && (!half_ctl[0].stall || clock_mode_enable);   // [RQ12] [RQ17]

  always_comb begin
    next_joined  = joined_count;
    next_loaded  = clock_loaded;
    events       = flags_t'(3'h0);
    oneshot_done = 2'h0;
    for (int h = 0; h < 2; h++) begin
      next_half[h] = half_counter[h];
      next_pre[h]  = prescale_count[h];
    end
    case (timer_configuration)
      CFG_JOINED_TIMER: begin                                   // [RQ3] [RQ7] [RQ19]
        if (load_write[0]) begin
          next_joined = pwdata;                                 // [RQ11]
        end else if (run_first) begin
          if (joined_count == 32'h00000000) begin
            next_joined     = joined_load;                      // [RQ8]
            events.first_to = 1'b1;                             // [RQ9]
            oneshot_done[0] = (counter_mode[0] == MODE_ONE_SHOT);  // [RQ7] [RQ8]
          end else begin
            next_joined = joined_count - 32'h00000001;
          end
        end
      end
      CFG_JOINED_CLOCK: begin                                   // [RQ3] [RQ13]
        if (!clock_loaded) begin
          next_joined = CLOCK_START;                            // [RQ13]
          next_loaded = 1'b1;
        end else if (run_first && clock_tick) begin
          if (joined_count == joined_match) begin
            next_joined        = CLOCK_ROLL;                    // [RQ15]
            events.clock_match = 1'b1;                          // [RQ16]
          end else begin
            next_joined = joined_count + 32'h00000001;          // [RQ15]
          end
        end
      end
      CFG_SPLIT: begin                                          // [RQ3] [RQ19]
        for (int h = 0; h < 2; h++) begin
          if (load_write[h]) begin
            next_half[h] = pwdata[15:0];                        // [RQ11]
            next_pre[h]  = prescale[h];
          end else if (half_ctl[h].en && !half_ctl[h].stall) begin   // [RQ12]
            if (counter_mode[h] == MODE_EDGE_COUNT) begin
              if (odd_rise) begin                               // [RQ18]
                if (half_counter[h] == 16'h0000) begin
                  next_half[h] = interval_load[h];
                  if (h == 0) events.first_to = 1'b1;
                  else        events.second_to = 1'b1;
                end else begin
                  next_half[h] = half_counter[h] - 16'h0001;
                end
              end
            end else if (prescale_count[h] != 8'h00) begin
              next_pre[h] = prescale_count[h] - 8'h01;
            end else begin
              next_pre[h] = prescale[h];
              if (half_counter[h] == 16'h0000) begin
                next_half[h]    = interval_load[h];
                oneshot_done[h] = (counter_mode[h] == MODE_ONE_SHOT);
                if (h == 0) events.first_to = 1'b1;
                else        events.second_to = 1'b1;
              end else begin
                next_half[h] = half_counter[h] - 16'h0001;
              end
            end
          end
        end
      end
      default: begin
      end
    endcase
    if (joined) begin
      next_half[0] = next_joined[15:0];                         // [RQ1]
      next_half[1] = next_joined[31:16];
    end
  end

  // ----------------------------------------------------------------
  // Counter state
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int h = 0; h < 2; h++) begin
        half_counter[h]   <= RST_COUNT;                         // [RQ4]
        prescale_count[h] <= RST_PRESCALE;
      end
      clock_loaded <= 1'b0;
    end else begin
      for (int h = 0; h < 2; h++) begin
        half_counter[h]   <= next_half[h];
        prescale_count[h] <= next_pre[h];
      end
      clock_loaded <= next_loaded;
    end
  end

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_configuration <= 3'h0;                              // [RQ4]
      clock_mode_enable   <= 1'b0;
      interrupt_mask      <= flags_t'(3'h0);
      for (int h = 0; h < 2; h++) begin
        counter_mode[h]  <= 2'h0;
        half_ctl[h]      <= half_ctl_t'(3'h0);
        interval_load[h] <= RST_LOAD;                           // [RQ4]
        match_value[h]   <= 16'h0000;
        prescale[h]      <= RST_PRESCALE;
      end
    end else begin
      for (int h = 0; h < 2; h++) begin
        if (oneshot_done[h]) half_ctl[h].en <= 1'b0;            // [RQ8]
      end
      if (wr) begin
        case (paddr)
          OFF_CONFIG:      timer_configuration <= pwdata[2:0];
          OFF_FIRST_MODE:  counter_mode[0] <= pwdata[1:0];
          OFF_SECOND_MODE: counter_mode[1] <= pwdata[1:0];
          OFF_MASK:        interrupt_mask <= word_flags(pwdata);
          OFF_CONTROL: begin
            clock_mode_enable <= pwdata[CTL_CLOCK_POS];
            for (int h = 0; h < 2; h++) begin
              half_ctl[h].en    <= pwdata[CTL_EN_POS + h * CTL_HALF_STRIDE];
              half_ctl[h].stall <= pwdata[CTL_STALL_POS + h * CTL_HALF_STRIDE];
              half_ctl[h].trig  <= pwdata[CTL_TRIG_POS + h * CTL_HALF_STRIDE];
            end
          end
          OFF_FIRST_LOAD: begin
            interval_load[0] <= pwdata[15:0];
            if (joined) interval_load[1] <= pwdata[31:16];      // [RQ5]
          end
          OFF_SECOND_LOAD: interval_load[1] <= pwdata[15:0];
          OFF_FIRST_MATCH: begin
            match_value[0] <= pwdata[15:0];                     // [RQ13]
            if (joined) match_value[1] <= pwdata[31:16];
          end
          OFF_SECOND_MATCH: match_value[1] <= pwdata[15:0];
          OFF_FIRST_PRE:    prescale[0] <= pwdata[7:0];
          OFF_SECOND_PRE:   prescale[1] <= pwdata[7:0];
          default: begin
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Status flags, interrupt and trigger
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      raw_interrupt_status <= flags_t'(3'h0);
      timer_irq            <= 1'b0;
      adc_trigger          <= 1'b0;
    end else begin
      // A new event in the clearing cycle survives the clear
      raw_interrupt_status <= (raw_interrupt_status & ~clear_bits) | events;   // [RQ9] [RQ16]
      timer_irq            <= |masked_interrupt_status;                        // [RQ20]
      adc_trigger          <= (events.first_to && half_ctl[0].trig) ||
                              (events.second_to && half_ctl[1].trig);          // [RQ2] [RQ10]
    end
  end

  // ----------------------------------------------------------------
  // APB read path: data latched in setup, answered in first access cycle
  // ----------------------------------------------------------------
  logic [31:0] read_word;

  always_comb begin
    read_word = 32'h00000000;
    case (paddr)
      OFF_CONFIG:       read_word = {29'h0, timer_configuration};
      OFF_FIRST_MODE:   read_word = {30'h0, counter_mode[0]};
      OFF_SECOND_MODE:  read_word = {30'h0, counter_mode[1]};
      OFF_CONTROL: begin
        read_word[CTL_CLOCK_POS] = clock_mode_enable;
        for (int h = 0; h < 2; h++) begin
          read_word[CTL_EN_POS + h * CTL_HALF_STRIDE]    = half_ctl[h].en;
          read_word[CTL_STALL_POS + h * CTL_HALF_STRIDE] = half_ctl[h].stall;
          read_word[CTL_TRIG_POS + h * CTL_HALF_STRIDE]  = half_ctl[h].trig;
        end
      end
      OFF_MASK:         read_word = flags_word(interrupt_mask);
      OFF_RAW:          read_word = flags_word(raw_interrupt_status);
      OFF_MASKED:       read_word = flags_word(masked_interrupt_status);
      OFF_FIRST_LOAD:   read_word = joined ? joined_load : {16'h0, interval_load[0]};
      OFF_SECOND_LOAD:  read_word = {16'h0, interval_load[1]};
      OFF_FIRST_MATCH:  read_word = joined ? joined_match : {16'h0, match_value[0]};
      OFF_SECOND_MATCH: read_word = {16'h0, match_value[1]};
      OFF_FIRST_PRE:    read_word = {24'h0, prescale[0]};
      OFF_SECOND_PRE:   read_word = {24'h0, prescale[1]};
      OFF_FIRST_VALUE:  read_word = joined ? joined_count : {16'h0, half_counter[0]};   // [RQ6]
      OFF_SECOND_VALUE: read_word = {16'h0, half_counter[1]};
      default:          read_word = 32'h00000000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup_phase;
      pslverr <= setup_phase && !is_mapped(paddr);
      if (setup_phase && !pwrite) prdata <= read_word;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic timer_busy;
  assign timer_busy = (timer_configuration == CFG_JOINED_TIMER) && run_first && !wr;

  sequence s_hit_zero;
    timer_busy && joined_count == 32'h00000000;
  endsequence

  sequence s_setup;
    psel && !penable;
  endsequence

  a_reload_at_zero: assert property (s_hit_zero |=> joined_count == $past(joined_load))   // [RQ8]
    else $error("joined counter did not reload after zero");

  a_oneshot_stops: assert property (s_hit_zero and counter_mode[0] == MODE_ONE_SHOT
                                   |=> !half_ctl[0].en)   // [RQ8]
    else $error("one-shot did not clear its enable");

  a_timeout_raw_set: assert property (s_hit_zero |=> raw_interrupt_status.first_to)   // [RQ9]
    else $error("timeout did not set raw flag");

  a_trigger_pulse: assert property (s_hit_zero and half_ctl[0].trig && !events.second_to
                                    |=> adc_trigger ##1 (adc_trigger == $past(events.first_to)))   // [RQ10]
    else $error("trigger pulse wrong");

  a_load_write_taken: assert property (wr && paddr == OFF_FIRST_LOAD && timer_configuration == CFG_JOINED_TIMER
                                       |=> joined_count == $past(pwdata))   // [RQ11]
    else $error("load write not taken next cycle");

  a_stall_holds: assert property (timer_configuration == CFG_JOINED_TIMER && half_ctl[0].stall &&
                                  !clock_mode_enable && !wr |=> $stable(joined_count))   // [RQ12]
    else $error("stalled counter moved");

  a_clock_first_load: assert property (timer_configuration == CFG_JOINED_CLOCK && !clock_loaded
                                       |=> joined_count == CLOCK_START)   // [RQ13]
    else $error("clock mode did not start at one");

  a_clock_rollover: assert property (timer_configuration == CFG_JOINED_CLOCK && clock_loaded && run_first &&
                                     clock_tick && joined_count == joined_match
                                     |=> joined_count == CLOCK_ROLL && raw_interrupt_status.clock_match)   // [RQ15] [RQ16]
    else $error("clock match did not roll over and flag");

  a_irq_follows: assert property (##1 timer_irq == $past(|masked_interrupt_status))   // [RQ20]
    else $error("interrupt output does not follow masked flags");

  a_apb_one_wait: assert property (s_setup |=> pready ##1 !pready)
    else $error("APB answer timing wrong");

endmodule : gp_timer_module

// ### tb/slow_clock_source.sv
// Partner model: slow clock source driving the even capture pin.
// Assumes the bench gates it with run; the pin rests low outside frames.
`timescale 1ns/1ps
module slow_clock_source #(
  parameter int HALF = 4
) (
  // Clock and gate
  input  wire logic pclk,
  input  wire logic run,
  // Pin
  output logic      pin
);
  int cnt = 0;
  initial pin = 1'b0;
  // Scaled stand-in for the 32.768 kHz source, stands still when idle
  always @(posedge pclk) begin
    if (!run) begin
      pin <= 1'b0;
      cnt <= 0;
    end else if (cnt == HALF - 1) begin
      pin <= ~pin;
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule : slow_clock_source

// ### tb/tb_gp_timer_module.sv
// Self-checking bench for the timer unit, APB master plus slow clock source.
// Assumes a zero-wait-state slave; every wait is still bounded.
`timescale 1ns/1ps
module tb_gp_timer_module;
  import gp_timer_pkg::*;
  typedef struct {logic w; logic [11:0] a; logic [31:0] d; logic [31:0] e; logic er;} row_t;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, run = 0, odd = 0, pin;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, err, adc_trigger, timer_irq;
  int failures = 0, n_tests = 0, cyc = 0, k;
  row_t rows[8] = '{'{0, OFF_CONFIG, 0, 0, 0}, '{0, OFF_CONTROL, 0, 0, 0},
    '{0, OFF_FIRST_VALUE, 0, 32'hFFFFFFFF, 0}, '{0, OFF_FIRST_PRE, 0, 0, 0}, '{0, OFF_RAW, 0, 0, 0},
    '{1, OFF_FIRST_LOAD, 32'h00020003, 0, 0}, '{0, OFF_SECOND_LOAD, 0, 32'h00000002, 0},
    '{0, 12'h100, 0, 0, 1}};
  always #4 pclk = ~pclk;
  gp_timer_module #(.CLOCK_DIVIDE(4)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .capture_pin_even(pin), .capture_pin_odd(odd),
    .adc_trigger(adc_trigger), .timer_irq(timer_irq));
  slow_clock_source #(.HALF(4)) i_src (.pclk(pclk), .run(run), .pin(pin));
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
    // A slave that never answers counts as a mismatch
    if (pready !== 1'b1) failures++;
    rd = prdata; err = pslverr; psel <= 0; penable <= 0;
  endtask : apb
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_tests++;
    if (s !== e) begin $display("[ERR] %s expected %h seen %h", nm, e, s); failures++; end
  endtask : chk
  task automatic give_verdict;
    if (failures == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict
  // Ceiling well above the few hundred cycles the sequence needs
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin failures++; give_verdict(); end
  end
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1;
    chk("irq_rst", 0, {adc_trigger, timer_irq});
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      chk("row_err", rows[i].er, err);
      if (!rows[i].w) chk("row", rows[i].e, rd);
    end
    apb(0, OFF_FIRST_VALUE, 0); chk("joined_val", 32'h00020003, rd);
    apb(1, OFF_FIRST_LOAD, 3); apb(1, OFF_FIRST_MODE, MODE_ONE_SHOT); apb(1, OFF_MASK, 1);
    apb(1, OFF_CONTROL, 32'h21);
    k = 0;
    while (adc_trigger !== 1'b1 && k < 100) begin @(posedge pclk); k++; end
    chk("trig_seen", 1, adc_trigger);
    @(posedge pclk); chk("trig_len", 0, adc_trigger);
    chk("irq_set", 1, timer_irq);
    apb(0, OFF_RAW, 0); chk("raw_to", 1, rd);
    // Only the enable drops; the trigger enable bit stays set
    apb(0, OFF_CONTROL, 0); chk("oneshot_off", 32'h20, rd);
    apb(0, OFF_FIRST_VALUE, 0); chk("reloaded", 3, rd);
    apb(1, OFF_CLEAR, 1); repeat (2) @(posedge pclk); chk("irq_clr", 0, timer_irq);
    apb(1, OFF_FIRST_MODE, MODE_PERIODIC); apb(1, OFF_CONTROL, 32'h03);
    repeat (10) @(posedge pclk);
    apb(0, OFF_FIRST_VALUE, 0); chk("stalled", 3, rd);
    apb(1, OFF_CONTROL, 32'h01); apb(0, OFF_FIRST_VALUE, 0); chk("resumed", 1, rd < 3);
    apb(1, OFF_CONTROL, 0); apb(1, OFF_CLEAR, 32'h109);
    apb(1, OFF_CONFIG, CFG_JOINED_CLOCK); apb(0, OFF_FIRST_VALUE, 0); chk("clk_start", 1, rd);
    apb(1, OFF_FIRST_MATCH, 2); apb(1, OFF_MASK, 32'h8); apb(1, OFF_CONTROL, 32'h13);
    run <= 1;
    k = 0;
    while (timer_irq !== 1'b1 && k < 800) begin @(posedge pclk); k++; end
    chk("irq_seen", 1, timer_irq);
    apb(0, OFF_RAW, 0); chk("clk_raw", 32'h8, rd);
    apb(0, OFF_FIRST_VALUE, 0); chk("clk_roll", 1, rd < 2);
    apb(1, OFF_CLEAR, 32'h8); apb(0, OFF_MASKED, 0); chk("clk_clr", 0, rd);
    // Split halves: second half counts odd-pin rises from a load of 2
    apb(1, OFF_CONTROL, 0);
    run <= 0;
    apb(1, OFF_CONFIG, CFG_SPLIT);
    apb(1, OFF_CLEAR, 32'h109);
    apb(1, OFF_SECOND_LOAD, 2);
    apb(1, OFF_SECOND_MODE, MODE_EDGE_COUNT);
    apb(1, OFF_CONTROL, 32'h100);
    repeat (3) begin
      odd <= 1;
      repeat (3) @(posedge pclk);
      odd <= 0;
      repeat (3) @(posedge pclk);
    end
    apb(0, OFF_RAW, 0); chk("split_raw", 32'h100, rd);
    chk("split_irq", 0, timer_irq);
    apb(0, OFF_SECOND_VALUE, 0); chk("split_val", 2, rd);
    give_verdict();
  end
endmodule : tb_gp_timer_module
